/* File: verilog/pckc_pkg.sv */
// constants, addresses and field layout for the pll core clock and key control block
// Operation
// RULE_01: pll locks to crystal, gives system clock
// RULE_02: core clock is pll over two to divider
// RULE_03: divider resets to code 010, divide four
// RULE_04: metering clock fixed at pll over five
// RULE_05: power control needs power key first
// RULE_06: timekeeping and interrupt pin need timekeeping key
// RULE_07: software returns key to zero afterwards
// RULE_08: key clears itself after timekeeping write
// RULE_09: protected write without preceding key ignored
// RULE_10: lock loss resets core, sets fault flag
// RULE_11: writing acknowledge bit clears fault flag
// RULE_12: metering off bit powers down metering; the code powers it down only when neither battery nor sleep state is set
// RULE_13: shutdown bit stops core in battery mode
// RULE_14: software keeps reserved bits at zero
// RULE_15: receive edge wake sets receive wake status
// RULE_16: rail source bit one on main supply
// RULE_17: supply good bit shows main supply adequate
// RULE_18: reference in sleep bit keeps reference on
// RULE_19: receive pin field selects pin function
// RULE_20: start bits request measurement, clear on accept
// RULE_21: measurement start bits are bit addressable
package pckc_pkg;
	// register addresses
	localparam logic [7:0] ADDR_KEY = 8'hc1;
	localparam logic [7:0] ADDR_POWER = 8'hc5;
	localparam logic [7:0] ADDR_MEAS = 8'hd8;
	localparam logic [7:0] ADDR_PERIPHERAL_CONFIGURATION = 8'hf4;
	localparam logic [7:0] ADDR_INTPIN = 8'hff;
	localparam logic [7:0] ADDR_FRAC = 8'ha2;
	localparam logic [7:0] ADDR_SEC = 8'ha3;
	localparam logic [7:0] ADDR_MIN = 8'ha4;
	localparam logic [7:0] ADDR_HOUR = 8'ha5;
	// bit addresses of measurement start
	localparam logic [7:0] BIT_ACK = 8'hdf;
	localparam logic [7:0] BIT_BASE = 8'hd8;
	// key values
	localparam logic [7:0] KEY_POWER = 8'ha7;
	localparam logic [7:0] KEY_TIME = 8'hea;
	localparam logic [7:0] KEY_RESET = 8'h00;
	// power control layout
	localparam logic [7:0] POWER_RESET = 8'h82;
	localparam logic [7:0] POWER_WMASK = 8'h77;
	localparam int POWER_METER_OFF = 6;
	localparam int POWER_CORE_OFF = 4;
	localparam logic [2:0] DIV_RESET = 3'h2;
	// peripheral configuration layout
	localparam int PER_RXWAKE = 7;
	localparam int PER_SOURCE = 6;
	localparam int PER_GOOD = 5;
	localparam int PER_FAULT = 4;
	localparam int PER_REF = 3;
	localparam logic [7:0] PER_WMASK = 8'h0f;
	localparam logic [7:0] PER_RESET = 8'h40;
	// measurement start layout
	localparam int MEAS_ACK = 7;
	localparam logic [2:0] MEAS_GO_MASK = 3'h7;
	// receive pin function codes
	localparam logic [1:0] RX_GPIO = 2'h0;
	localparam logic [1:0] RX_NOWAKE = 2'h1;
	localparam logic [1:0] RX_WAKE = 2'h3;
	// clocking
	localparam int PLL_HZ = 4096000;
	localparam int XTAL_HZ = 32768;
	localparam int PLL_MULT = PLL_HZ / XTAL_HZ;
	localparam int METER_DIV = 5;
	localparam int DIV_MAX = 7;
endpackage

/* File: verilog/pckc_core_divider.sv */
// binary core clock divider with selectable power of two
`timescale 1ns/1ps
module pckc_core_divider #(
	parameter int DIV_BITS = 3
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// control
	input wire logic [DIV_BITS-1:0] div_sel_in,
	// output
	output logic core_tick_out
);
	localparam int CW = (1 << DIV_BITS);
	if (DIV_BITS < 1 || DIV_BITS > 4) begin : g_bad_width
		$error("divider width out of range");
	end
	logic [CW-1:0] count_q;
	logic [CW-1:0] mask;
	always_comb begin
		mask = (CW'(1) << div_sel_in) - CW'(1);
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_q <= '0;
		end else if ((count_q & mask) == mask) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + CW'(1);
		end
	end
	// one tick every two to the divider pll cycles
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			core_tick_out <= 1'b0;
		end else begin
			core_tick_out <= ((count_q & mask) == mask); // RULE_02
		end
	end
endmodule

/* File: verilog/pckc_meter_divider.sv */
// fixed divide by n tick for the metering clock
`timescale 1ns/1ps
module pckc_meter_divider #(
	parameter int DIVIDE = 5
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// output
	output logic tick_out
);
	localparam int W = $clog2(DIVIDE);
	if (DIVIDE < 2) begin : g_bad_divide
		$error("metering divide too small");
	end
	logic [W-1:0] count_q;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_q <= '0;
		end else if (count_q == W'(DIVIDE - 1)) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + W'(1);
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= (count_q == W'(DIVIDE - 1)); // RULE_04
		end
	end
endmodule

/* File: verilog/pckc_top.sv */
// clock, power and key control registers behind the special function bus
`timescale 1ns/1ps
module pckc_top (
	// clock and reset (core_clk_in is the pll clock)
	input wire logic core_clk_in,
	input wire logic reset_in,
	// special function register bus
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic bit_wr_in,
	input wire logic [7:0] bit_addr_in,
	input wire logic bit_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// pll and supply status
	input wire logic pll_locked_in,
	input wire logic supply_good_in,
	input wire logic rail_on_main_in,
	input wire logic battery_state_in,
	input wire logic sleep_state_in,
	input wire logic rx_edge_in,
	// auxiliary adc handshake
	input wire logic [2:0] adc_accept_in,
	output logic [2:0] adc_request_out,
	// clock and power controls
	output logic core_tick_out,
	output logic meter_tick_out,
	output logic core_reset_out,
	output logic core_shutdown_out,
	output logic meter_power_down_out,
	output logic reference_in_sleep_out,
	output logic [1:0] receive_pin_function_out,
	output logic receive_wake_enable_out,
	// timekeeping write strobes
	output logic time_write_out,
	output logic [7:0] time_addr_out,
	output logic [7:0] time_wdata_out
);
	logic [7:0] write_unlock_key_q;
	logic [7:0] power_and_clock_control_q;
	logic [7:0] peripheral_configuration_q;
	logic [7:0] aux_measurement_start_q;
	logic lock_lost_fault_flag_q;
	logic pll_locked_q;
	logic power_wr, time_wr, meas_wr, per_wr, key_wr;
	logic [2:0] go_set;
	logic ack_set;
	logic core_tick, meter_tick;

	function automatic logic is_time_addr(input logic [7:0] a);
		is_time_addr = (a == pckc_pkg::ADDR_INTPIN) || (a == pckc_pkg::ADDR_FRAC) ||
			(a == pckc_pkg::ADDR_SEC) || (a == pckc_pkg::ADDR_MIN) ||
			(a == pckc_pkg::ADDR_HOUR);
	endfunction

	// write decode with key gating
	always_comb begin
		key_wr = sfr_wr_in && (sfr_addr_in == pckc_pkg::ADDR_KEY);
		power_wr = sfr_wr_in && (sfr_addr_in == pckc_pkg::ADDR_POWER) &&
			(write_unlock_key_q == pckc_pkg::KEY_POWER); // RULE_05 RULE_09
		time_wr = sfr_wr_in && is_time_addr(sfr_addr_in) &&
			(write_unlock_key_q == pckc_pkg::KEY_TIME); // RULE_06 RULE_09
		meas_wr = sfr_wr_in && (sfr_addr_in == pckc_pkg::ADDR_MEAS);
		per_wr = sfr_wr_in && (sfr_addr_in == pckc_pkg::ADDR_PERIPHERAL_CONFIGURATION);
		go_set = '0;
		ack_set = 1'b0;
		if (meas_wr) begin
			go_set = sfr_wdata_in[2:0] & pckc_pkg::MEAS_GO_MASK;
			ack_set = sfr_wdata_in[pckc_pkg::MEAS_ACK];
		end
		if (bit_wr_in && bit_wdata_in) begin
			if (bit_addr_in == pckc_pkg::BIT_ACK) begin
				ack_set = 1'b1; // RULE_21
			end else if (bit_addr_in >= pckc_pkg::BIT_BASE &&
				bit_addr_in < pckc_pkg::BIT_BASE + 8'h03) begin
				go_set[bit_addr_in[1:0]] = 1'b1; // RULE_21
			end
		end
	end

	// key register: any other sfr byte write consumes the key, bit writes leave it
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			write_unlock_key_q <= pckc_pkg::KEY_RESET;
		end else if (key_wr) begin
			write_unlock_key_q <= sfr_wdata_in;
		end else if (sfr_wr_in) begin
			write_unlock_key_q <= pckc_pkg::KEY_RESET; // RULE_08 RULE_09
		end
	end

	// power and clock control
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			power_and_clock_control_q <= pckc_pkg::POWER_RESET; // RULE_03
		end else if (power_wr) begin
			power_and_clock_control_q <= (sfr_wdata_in & pckc_pkg::POWER_WMASK) |
				(pckc_pkg::POWER_RESET & ~pckc_pkg::POWER_WMASK); // RULE_05
		end
	end

	// pll lock tracking and fault flag, set wins over acknowledge
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pll_locked_q <= 1'b0;
			lock_lost_fault_flag_q <= 1'b0;
		end else begin
			pll_locked_q <= pll_locked_in; // RULE_01
			if (pll_locked_q && !pll_locked_in) begin
				lock_lost_fault_flag_q <= 1'b1; // RULE_10
			end else if (ack_set) begin
				lock_lost_fault_flag_q <= 1'b0; // RULE_11
			end
		end
	end

	// peripheral configuration
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			peripheral_configuration_q <= pckc_pkg::PER_RESET;
		end else begin
			peripheral_configuration_q[pckc_pkg::PER_SOURCE] <= rail_on_main_in; // RULE_16
			peripheral_configuration_q[pckc_pkg::PER_GOOD] <= supply_good_in; // RULE_17
			peripheral_configuration_q[pckc_pkg::PER_FAULT] <= 1'b0;
			if (sleep_state_in && rx_edge_in &&
				peripheral_configuration_q[1:0] == pckc_pkg::RX_WAKE) begin
				peripheral_configuration_q[pckc_pkg::PER_RXWAKE] <= 1'b1; // RULE_15
			end else if (per_wr && !sfr_wdata_in[pckc_pkg::PER_RXWAKE]) begin
				peripheral_configuration_q[pckc_pkg::PER_RXWAKE] <= 1'b0;
			end
			if (per_wr) begin
				peripheral_configuration_q[3:0] <= sfr_wdata_in[3:0] &
					pckc_pkg::PER_WMASK[3:0]; // RULE_18 RULE_19
			end
		end
	end

	// measurement start bits, set wins over accept
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			aux_measurement_start_q <= 8'h00;
		end else begin
			aux_measurement_start_q[7:3] <= 5'h00;
			aux_measurement_start_q[2:0] <= go_set |
				(aux_measurement_start_q[2:0] & ~adc_accept_in); // RULE_20
		end
	end

	// read mux
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			sfr_rdata_out <= 8'h00;
		end else if (sfr_rd_in) begin
			case (sfr_addr_in)
				pckc_pkg::ADDR_KEY: sfr_rdata_out <= write_unlock_key_q;
				pckc_pkg::ADDR_POWER: sfr_rdata_out <= power_and_clock_control_q;
				pckc_pkg::ADDR_MEAS: sfr_rdata_out <= aux_measurement_start_q;
				pckc_pkg::ADDR_PERIPHERAL_CONFIGURATION: begin
					sfr_rdata_out <= peripheral_configuration_q;
					sfr_rdata_out[pckc_pkg::PER_FAULT] <= lock_lost_fault_flag_q;
				end
				default: sfr_rdata_out <= 8'h00;
			endcase
		end
	end

	// timekeeping write forwarding
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			time_write_out <= 1'b0;
			time_addr_out <= 8'h00;
			time_wdata_out <= 8'h00;
		end else begin
			time_write_out <= time_wr; // RULE_06
			if (time_wr) begin
				time_addr_out <= sfr_addr_in;
				time_wdata_out <= sfr_wdata_in;
			end
		end
	end

	// control outputs
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			core_reset_out <= 1'b1;
			core_shutdown_out <= 1'b0;
			meter_power_down_out <= 1'b0;
			reference_in_sleep_out <= 1'b0;
			receive_pin_function_out <= pckc_pkg::RX_GPIO;
			receive_wake_enable_out <= 1'b0;
			adc_request_out <= 3'h0;
			core_tick_out <= 1'b0;
			meter_tick_out <= 1'b0;
		end else begin
			core_reset_out <= pll_locked_q && !pll_locked_in; // RULE_10
			core_shutdown_out <= battery_state_in &&
				power_and_clock_control_q[pckc_pkg::POWER_CORE_OFF]; // RULE_13
			meter_power_down_out <= !battery_state_in && !sleep_state_in &&
				power_and_clock_control_q[pckc_pkg::POWER_METER_OFF]; // RULE_12
			reference_in_sleep_out <= sleep_state_in &&
				peripheral_configuration_q[pckc_pkg::PER_REF]; // RULE_18
			receive_pin_function_out <= peripheral_configuration_q[1:0]; // RULE_19
			receive_wake_enable_out <= peripheral_configuration_q[1:0] == pckc_pkg::RX_WAKE;
			adc_request_out <= aux_measurement_start_q[2:0]; // RULE_20
			core_tick_out <= core_tick;
			meter_tick_out <= meter_tick;
		end
	end

	pckc_core_divider #(
		.DIV_BITS(3)
	) pckc_core_divider_i (
		.clk_in(core_clk_in),
		.reset_in(reset_in),
		.div_sel_in(power_and_clock_control_q[2:0]),
		.core_tick_out(core_tick)
	);

	pckc_meter_divider #(
		.DIVIDE(pckc_pkg::METER_DIV)
	) pckc_meter_divider_i (
		.clk_in(core_clk_in),
		.reset_in(reset_in),
		.tick_out(meter_tick)
	);
endmodule

/* File: tb/pckc_top_monitor.sv */
// bound assertions on the block's ports
`timescale 1ns/1ps
module pckc_top_monitor (
	// clock, reset and bus
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	// status and controls
	input wire logic pll_locked_in,
	input wire logic [2:0] adc_accept_in,
	input wire logic [2:0] adc_request_out,
	input wire logic meter_tick_out,
	input wire logic core_reset_out,
	input wire logic [1:0] receive_pin_function_out,
	input wire logic receive_wake_enable_out,
	input wire logic time_write_out,
	input wire logic [7:0] time_addr_out,
	input wire logic [7:0] time_wdata_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// last bus write was the timekeeping key
	logic time_key_last_q;
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			time_key_last_q <= 1'b0;
		end else if (sfr_wr_in) begin
			time_key_last_q <= (sfr_addr_in == pckc_pkg::ADDR_KEY) &&
				(sfr_wdata_in == pckc_pkg::KEY_TIME);
		end
	end
	property p_meter; meter_tick_out |=> !meter_tick_out [*4] ##1 meter_tick_out; endproperty
	a_meter: assert property (p_meter) else $error("meter tick spacing");
	property p_lock; $fell(pll_locked_in) |-> ##[0:2] core_reset_out; endproperty
	a_lock: assert property (p_lock) else $error("no core reset");
	property p_rst; core_reset_out |=> !core_reset_out; endproperty
	a_rst: assert property (p_rst) else $error("core reset too long");
	property p_tw; time_write_out |-> $past(sfr_wr_in) && time_wdata_out == $past(sfr_wdata_in)
		&& time_addr_out == $past(sfr_addr_in); endproperty
	a_tw: assert property (p_tw) else $error("time write mismatch");
	property p_tkey; time_write_out |-> $past(time_key_last_q); endproperty
	a_tkey: assert property (p_tkey) else $error("time write without key");
	property p_tone; time_write_out |=> !time_write_out; endproperty
	a_tone: assert property (p_tone) else $error("key not cleared");
	property p_adc; adc_request_out[0] && adc_accept_in[0] |-> ##[1:3] !adc_request_out[0];
		endproperty
	a_adc: assert property (p_adc) else $error("request not cleared");
	property p_wake; receive_wake_enable_out == (receive_pin_function_out == pckc_pkg::RX_WAKE);
		endproperty
	a_wake: assert property (p_wake) else $error("wake enable wrong");
endmodule
bind pckc_top pckc_top_monitor pckc_top_monitor_i (.core_clk_in, .reset_in, .sfr_wr_in,
	.sfr_addr_in, .sfr_wdata_in, .pll_locked_in, .adc_accept_in, .adc_request_out,
	.meter_tick_out, .core_reset_out, .receive_pin_function_out, .receive_wake_enable_out,
	.time_write_out, .time_addr_out, .time_wdata_out);

/* File: tb/pckc_adc_model.sv */
// auxiliary adc model accepting measurement requests
`timescale 1ns/1ps
module pckc_adc_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// handshake
	input wire logic slow_in,
	input wire logic [2:0] request_in,
	output logic [2:0] accept_out
);
	logic [7:0] wait_q;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wait_q <= 8'h00;
		end else if (request_in == 3'h0) begin
			wait_q <= 8'h00;
		end else if (wait_q != 8'hff) begin
			wait_q <= wait_q + 8'h01;
		end
	end
	// one accept per request, prompt or slow
	assign accept_out = (wait_q == (slow_in ? 8'h06 : 8'h01)) ? request_in : 3'h0;
endmodule

/* File: tb/pckc_top_tb_top.sv */
// self-checking bench for the clock, power and key block
`timescale 1ns/1ps
module pckc_top_tb_top;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bwr = 1'b0, lock = 1'b1, good = 1'b0;
	logic rail = 1'b1, bat = 1'b0, slp = 1'b0, rxe = 1'b0, slow = 1'b0, tseen;
	logic [7:0] adr = 8'h00, wd = 8'h00, badr = 8'h00, rdat, rv, ta, td;
	logic [7:0] tk[5] = '{8'hff, 8'ha2, 8'ha3, 8'ha4, 8'ha5};
	logic [7:0] fc[3] = '{8'h00, 8'h01, 8'h03};
	logic [2:0] req, acc;
	logic [1:0] fn;
	logic ct, mt, cr, cs, mpd, rf, wen, tw;
	int fails = 0, total_checks = 0, cyc = 0, i, j, n;
	pckc_top pckc_top_i (.core_clk_in(clk), .reset_in(rst), .sfr_wr_in(wr), .sfr_rd_in(rd),
		.sfr_addr_in(adr), .sfr_wdata_in(wd), .bit_wr_in(bwr), .bit_addr_in(badr),
		.bit_wdata_in(1'b1), .sfr_rdata_out(rdat), .pll_locked_in(lock), .supply_good_in(good),
		.rail_on_main_in(rail), .battery_state_in(bat), .sleep_state_in(slp), .rx_edge_in(rxe),
		.adc_accept_in(acc), .adc_request_out(req), .core_tick_out(ct), .meter_tick_out(mt),
		.core_reset_out(cr), .core_shutdown_out(cs), .meter_power_down_out(mpd),
		.reference_in_sleep_out(rf), .receive_pin_function_out(fn),
		.receive_wake_enable_out(wen), .time_write_out(tw), .time_addr_out(ta),
		.time_wdata_out(td));
	pckc_adc_model pckc_adc_model_i (.clk_in(clk), .reset_in(rst), .slow_in(slow),
		.request_in(req), .accept_out(acc));
	always #10 clk = ~clk;
	task automatic print_verdict();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// key write then target write back to back, watching for a time write
	task automatic kw(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
		tseen = 1'b0;
		wr = 1'b1;
		adr = 8'hc1;
		wd = k;
		@(negedge clk);
		adr = a;
		wd = d;
		repeat (3) begin
			@(negedge clk);
			wr = 1'b0;
			if (tw === 1'b1 && ta === a && td === d) tseen = 1'b1;
		end
	endtask
	task automatic rdr(input logic [7:0] a);
		rd = 1'b1;
		adr = a;
		@(negedge clk);
		rv = rdat;
		rd = 1'b0;
		@(negedge clk);
	endtask
	task automatic bset(input logic [7:0] a);
		bwr = 1'b1;
		badr = a;
		@(negedge clk);
		bwr = 1'b0;
		@(negedge clk);
	endtask
	// cycles between two ticks
	task automatic per(input logic m, input int e);
		n = 0;
		while ((m ? mt : ct) !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((m ? mt : ct) !== 1'b1 && n < 300);
		chk(m ? "meter period" : "core period", n[7:0], e[7:0]);
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		rdr(8'hc5);
		chk("power", rv, 8'h82);
		rdr(8'hc1);
		chk("key", rv, 8'h00);
		rdr(8'hf4);
		chk("peripheral_configuration", rv, 8'h40);
		per(1'b0, 4);
		kw(8'h00, 8'hc5, 8'h00);
		rdr(8'hc5);
		chk("power", rv, 8'h82);
		for (i = 0; i < 8; i++) begin
			kw(8'ha7, 8'hc5, i[7:0]);
			rdr(8'hc5);
			chk("power", rv, 8'h80 | i[7:0]);
			per(1'b0, 1 << i);
			per(1'b1, 5);
		end
		kw(8'ha7, 8'hc5, 8'h42);
		chk("meter off", {7'h00, mpd}, 8'h01);
		bat = 1'b1;
		rdr(8'hc5);
		chk("meter off", {7'h00, mpd}, 8'h00);
		kw(8'ha7, 8'hc5, 8'h12);
		chk("core off", {7'h00, cs}, 8'h01);
		bat = 1'b0;
		kw(8'hea, 8'hc5, 8'h00);
		chk("core off", {7'h00, cs}, 8'h00);
		rdr(8'hc5);
		chk("power", rv, 8'h92);
		foreach (tk[j]) begin
			kw(8'hea, tk[j], 8'h3c);
			chk("time write", {7'h00, tseen}, 8'h01);
			rdr(8'hc1);
			chk("key", rv, 8'h00);
		end
		kw(8'ha7, 8'ha3, 8'h3c);
		chk("time write", {7'h00, tseen}, 8'h00);
		kw(8'h00, 8'hff, 8'h3c);
		chk("time write", {7'h00, tseen}, 8'h00);
		good = 1'b1;
		rail = 1'b0;
		foreach (fc[j]) begin
			kw(8'h00, 8'hf4, 8'h08 | fc[j]);
			chk("pin function", {6'h00, fn}, fc[j]);
			chk("wake enable", {7'h00, wen}, {7'h00, fc[j] == 8'h03});
			chk("ref sleep", {7'h00, rf}, 8'h00);
			rdr(8'hf4);
			chk("peripheral_configuration", rv, 8'h28 | fc[j]);
		end
		slp = 1'b1;
		rxe = 1'b1;
		@(negedge clk);
		rxe = 1'b0;
		rdr(8'hf4);
		chk("ref sleep", {7'h00, rf}, 8'h01);
		slp = 1'b0;
		chk("peripheral_configuration", rv, 8'hab);
		lock = 1'b0;
		@(negedge clk);
		chk("core reset", {7'h00, cr}, 8'h01);
		rdr(8'hf4);
		chk("peripheral_configuration", rv, 8'hbb);
		lock = 1'b1;
		bset(8'hdf);
		rdr(8'hf4);
		chk("peripheral_configuration", rv, 8'hab);
		for (i = 0; i < 6; i++) begin
			slow = i[0];
			bset(8'hd8 + 8'(i / 2));
			chk("request", {5'h00, req}, 8'h01 << (i / 2));
			n = 0;
			while (req !== 3'h0 && n < 20) begin
				@(negedge clk);
				n++;
			end
			rdr(8'hd8);
			chk("start bits", rv & 8'h07, 8'h00);
		end
		lock = 1'b0;
		@(negedge clk);
		lock = 1'b1;
		kw(8'h00, 8'hd8, 8'h84);
		chk("request", {5'h00, req}, 8'h04);
		rdr(8'hf4);
		chk("peripheral_configuration", rv, 8'hab);
		n = 0;
		while (req !== 3'h0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		rdr(8'hd8);
		chk("start bits", rv & 8'h07, 8'h00);
		print_verdict();
	end
endmodule
